/* File: rpd_regs.vh */
/*
  Constants for the dual signal-strength peak detector block: register
  offsets, reset values and field widths.
  Assumes it is included by its bare name from the design files.
*/
// Notes on behaviour
// - Converter samples arrive as unsigned 8-bit values and feed the peak logic.
// - Each sample spans codes 0 to 255, noise low, strong input high.
// - Four consecutive samples are averaged; only averages reach both detectors.
// - Two independent detectors: telegram payload and free-running.
// - Telegram detector observes from frame sync until end of message.
// - Frame sync clears the telegram detector's internal peak to zero.
// - Tracking start after frame sync is delayed by a set count of bits.
// - End of message copies the internal peak into the payload register.
// - Payload register holds the last telegram's peak; only reset clears it.
// - Free-running detector tracks only while the receiver-run signal is high.
// - Free-running peak is replaced whenever a new average exceeds it.
// - While running, each running-peak read refreshes the register and restarts tracking.
// - While not running, a read leaves the held value unchanged.
// - Free-running register is cleared to zero by reset.
`ifndef RPD_REGS_VH
`define RPD_REGS_VH

`define RPD_ADDR_PAYLOAD_PEAK 8'hAC
`define RPD_ADDR_RUNNING_PEAK 8'hAD
`define RPD_PAYLOAD_PEAK_RST 8'h00
`define RPD_RUNNING_PEAK_RST 8'h00
`define RPD_SAMPLE_W 8
`define RPD_AVG_GROUP 3'h4
`define RPD_BITCNT_W 8

`endif

/* File: rpd_avg4.v */
/*
  Four-sample averager for signal-strength samples.
  Assumes samples arrive as single-cycle valid strobes on the system clock.
*/
`timescale 1ns/1ps
`include "rpd_regs.vh"
module rpd_avg4 #(
  parameter W = 8
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rstn,
  // Samples in
  input wire i_smp_vld,
  input wire [W-1:0] i_smp,
  // Average out
  output reg o_avg_vld,
  output reg [W-1:0] o_avg
);

  reg [W+1:0] acc;
  reg [1:0] cnt;
  wire [W+1:0] sum;

  assign sum = acc + {2'b00, i_smp};

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      acc <= {(W+2){1'b0}};
      cnt <= 2'h0;
      o_avg_vld <= 1'b0;
      o_avg <= {W{1'b0}};
    end else begin
      o_avg_vld <= 1'b0;
      if (i_smp_vld) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) begin
          acc <= {(W+2){1'b0}};
          o_avg <= sum[W+1:2];
          o_avg_vld <= 1'b1;
        end else begin
          acc <= sum;
        end
      end
    end
  end

endmodule // rpd_avg4

/* File: rpd_peak_det.v */
/*
  Dual peak-level detector for the digitised signal strength: a telegram
  payload detector and a free-running detector, read at fixed addresses.
  Assumes frame sync, end of message and data-bit strobes are one-cycle
  pulses from framer logic on the same clock; register reads arrive as a
  one-cycle read strobe with an address from the serial register port.
*/
`timescale 1ns/1ps
`include "rpd_regs.vh"
module rpd_peak_det #(
  parameter W = 8,
  parameter BW = 8
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rstn,
  // Converter samples
  input wire i_smp_vld,
  input wire [W-1:0] i_received_signal_strength,
  // Receiver framing
  input wire i_rx_run,
  input wire i_frame_sync_found,
  input wire i_end_of_message,
  input wire i_data_bit_strobe,
  input wire [BW-1:0] i_peak_start_bit_delay,
  // Register read port
  input wire i_rd_stb,
  input wire [7:0] i_rd_addr,
  output reg [7:0] o_rd_data,
  output reg o_rd_hit,
  // Direct views
  output reg [W-1:0] o_payload_peak_level,
  output reg [W-1:0] o_running_peak_level
);

  ////////////////////////////////////////////////////////////////////////
  // Averaging

  wire avg_vld;
  wire [W-1:0] avg;

  rpd_avg4 #(
    .W(W)
  ) u_avg (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_smp_vld(i_smp_vld),
    .i_smp(i_received_signal_strength),
    .o_avg_vld(avg_vld),
    .o_avg(avg)
  );

  ////////////////////////////////////////////////////////////////////////
  // Telegram detector

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_TRACK = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [BW-1:0] bit_cnt;
  reg [BW-1:0] next_bit_cnt;
  reg [W-1:0] tel_peak;
  reg [W-1:0] next_tel_peak;
  reg [W-1:0] next_payload_peak;
  wire [BW-1:0] bit_cnt_inc;
  wire [1:0] restart_state;
  wire delay_zero;
  wire delay_done;
  wire in_frame;
  wire frame_close;
  wire frame_restart;
  wire bit_step;
  wire tel_hi;
  wire tel_take;

  assign bit_cnt_inc = bit_cnt + {{(BW-1){1'b0}}, 1'b1};
  assign delay_zero = (i_peak_start_bit_delay == {BW{1'b0}});
  assign delay_done = (bit_cnt_inc >= i_peak_start_bit_delay);
  // A zero delay starts tracking on the edge after sync
  assign restart_state = delay_zero ? ST_TRACK : ST_WAIT;
  assign in_frame = (state == ST_WAIT) || (state == ST_TRACK);
  // End of message wins over a same-cycle sync
  assign frame_close = in_frame && i_end_of_message;
  // A sync inside a frame restarts it, as in idle
  assign frame_restart = i_frame_sync_found && !frame_close;
  assign bit_step = (state == ST_WAIT) && i_data_bit_strobe &&
    !i_end_of_message && !i_frame_sync_found;
  assign tel_hi = avg_vld && (avg > tel_peak);
  assign tel_take = (state == ST_TRACK) && tel_hi &&
    !i_end_of_message && !i_frame_sync_found;

  ////////////////////////////////////////////////////////////////////////
  // Telegram tracker next values

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_restart) begin
          next_state = restart_state;
        end
      end
      ST_WAIT: begin
        if (frame_close) begin
          next_state = ST_IDLE;
        end else if (frame_restart) begin
          next_state = restart_state;
        end else if (bit_step && delay_done) begin
          next_state = ST_TRACK;
        end
      end
      ST_TRACK: begin
        if (frame_close) begin
          next_state = ST_IDLE;
        end else if (frame_restart) begin
          next_state = restart_state;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Counts data bits only while waiting out the start delay
  always @* begin
    next_bit_cnt = bit_cnt;
    if (frame_restart) begin
      next_bit_cnt = {BW{1'b0}};
    end else if (bit_step) begin
      next_bit_cnt = bit_cnt_inc;
    end
  end

  always @* begin
    next_tel_peak = tel_peak;
    if (frame_restart) begin
      next_tel_peak = {W{1'b0}};
    end else if (tel_take) begin
      next_tel_peak = avg;
    end
  end

  // An end of message in idle is stale and publishes nothing
  always @* begin
    next_payload_peak = o_payload_peak_level;
    if (frame_close) begin
      next_payload_peak = tel_peak;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Telegram tracker registers

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      bit_cnt <= {BW{1'b0}};
      tel_peak <= {W{1'b0}};
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      tel_peak <= next_tel_peak;
    end
  end

  // Only end of message or reset moves the payload register
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_payload_peak_level <= `RPD_PAYLOAD_PEAK_RST;
    end else begin
      o_payload_peak_level <= next_payload_peak;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Free-running detector

  reg [W-1:0] run_peak;
  reg [W-1:0] next_run_peak;
  reg [W-1:0] next_running_peak;
  wire run_rd;
  wire run_hi;
  wire [W-1:0] run_seed;
  wire [W-1:0] run_refresh;

  assign run_rd = i_rd_stb && (i_rd_addr == `RPD_ADDR_RUNNING_PEAK);
  assign run_hi = avg_vld && (avg > run_peak);
  // An average landing with the read seeds the restart, so it is not lost
  assign run_seed = avg_vld ? avg : {W{1'b0}};
  // Register keeps the larger of the stored peak and a same-cycle average
  assign run_refresh = run_hi ? avg : run_peak;

  // Detector restarts on every running-peak read while the receiver runs
  always @* begin
    next_run_peak = run_peak;
    if (i_rx_run) begin
      if (run_rd) begin
        next_run_peak = run_seed;
      end else if (run_hi) begin
        next_run_peak = avg;
      end
    end else begin
      next_run_peak = run_peak;
    end
  end

  // Register takes the refreshed peak on a read, then follows new highs
  always @* begin
    next_running_peak = o_running_peak_level;
    if (i_rx_run) begin
      if (run_rd) begin
        next_running_peak = run_refresh;
      end else if (run_hi) begin
        next_running_peak = avg;
      end
    end else begin
      // A read while stopped changes nothing
      next_running_peak = o_running_peak_level;
    end
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      run_peak <= {W{1'b0}};
    end else begin
      run_peak <= next_run_peak;
    end
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_running_peak_level <= `RPD_RUNNING_PEAK_RST;
    end else begin
      o_running_peak_level <= next_running_peak;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  reg [7:0] next_rd_data;
  reg next_rd_hit;
  wire pay_sel;
  wire run_sel;

  assign pay_sel = (i_rd_addr == `RPD_ADDR_PAYLOAD_PEAK);
  assign run_sel = (i_rd_addr == `RPD_ADDR_RUNNING_PEAK);

  // Data holds between reads; an unmapped read returns zero
  always @* begin
    next_rd_data = o_rd_data;
    if (i_rd_stb) begin
      case (i_rd_addr)
        `RPD_ADDR_PAYLOAD_PEAK: begin
          next_rd_data = o_payload_peak_level;
        end
        `RPD_ADDR_RUNNING_PEAK: begin
          // Value before this cycle's refresh
          next_rd_data = o_running_peak_level;
        end
        default: begin
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  // Hit marks a mapped read only
  always @* begin
    next_rd_hit = 1'b0;
    if (i_rd_stb) begin
      next_rd_hit = pay_sel || run_sel;
    end
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_hit <= 1'b0;
    end else begin
      o_rd_hit <= next_rd_hit;
    end
  end

endmodule // rpd_peak_det

/* File: rpd_peak_det_chk.sv */
/* Checker for the peak detector read port and registers.
   Assumes one clock and bind to rpd_peak_det. */
`timescale 1ns/1ps
`include "rpd_regs.vh"
module rpd_peak_det_chk #(
  parameter W = 8
) (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_rx_run,
  input wire i_end_of_message,
  input wire i_rd_stb,
  input wire [7:0] i_rd_addr,
  input wire [7:0] o_rd_data,
  input wire o_rd_hit,
  input wire [W-1:0] o_payload_peak_level,
  input wire [W-1:0] o_running_peak_level
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire rd_ac = i_rd_stb && i_rd_addr == `RPD_ADDR_PAYLOAD_PEAK;
  wire rd_ad = i_rd_stb && i_rd_addr == `RPD_ADDR_RUNNING_PEAK;
  chk_pay_hold: assert property (!i_end_of_message |=> $stable(o_payload_peak_level))
    else $error("payload peak moved without end of message");
  chk_rd_pay: assert property (
    rd_ac |=> o_rd_hit && o_rd_data == $past(o_payload_peak_level))
    else $error("payload read data wrong");
  chk_rd_run: assert property (
    rd_ad |=> o_rd_hit && o_rd_data == $past(o_running_peak_level))
    else $error("running read data wrong");
  chk_rd_unmap: assert property (
    i_rd_stb && !rd_ac && !rd_ad |=> !o_rd_hit && o_rd_data == 8'h00)
    else $error("unmapped read answered");
  chk_hit_cause: assert property (o_rd_hit |-> $past(i_rd_stb))
    else $error("hit without read");
  chk_data_hold: assert property (!i_rd_stb |=> $stable(o_rd_data))
    else $error("read data moved without read");
  chk_run_hold: assert property (!i_rx_run |=> $stable(o_running_peak_level))
    else $error("running peak moved while idle");
  chk_run_idle_rd: assert property (rd_ad && !i_rx_run |=> $stable(o_running_peak_level))
    else $error("running peak moved on a read while stopped");
  cover property (i_end_of_message);
  cover property (rd_ad && i_rx_run);
  cover property (rd_ac);
endmodule // rpd_peak_det_chk
bind rpd_peak_det rpd_peak_det_chk #(.W(W)) chk (.i_clk_sys, .i_rstn, .i_rx_run, .i_end_of_message,
  .i_rd_stb, .i_rd_addr, .o_rd_data, .o_rd_hit, .o_payload_peak_level, .o_running_peak_level);

/* File: rpd_host.sv */
/* Host model issuing register reads.
   Assumes reads taken on the rising clock edge. */
`timescale 1ns/1ps
module rpd_host (
  // Clock
  input wire i_clk_sys,
  // Read port
  output reg o_rd_stb = 1'b0,
  output reg [7:0] o_rd_addr = 8'h00
);
  task rd(input [7:0] a);
    begin
      @(posedge i_clk_sys);
      o_rd_stb <= 1'b1;
      o_rd_addr <= a;
      @(posedge i_clk_sys);
      o_rd_stb <= 1'b0;
      // Scrambled so no stale address lingers
      o_rd_addr <= ~a;
    end
  endtask
endmodule // rpd_host

/* File: tb.sv */
/* Testbench for rpd_peak_det with a host read model.
   Assumes a 100 MHz clock and the checker bound in. */
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, rstn = 1'b0, vld = 1'b0, run = 1'b0, sync = 1'b0, end_of_message = 1'b0, bs = 1'b0;
  reg [7:0] smp = 8'h00, dly = 8'h00, e_pay, e_run, a;
  wire stb, hit;
  wire [7:0] addr, rdd, pay, runv;
  reg [7:0] q[$];
  integer failures = 0, num_checks = 0;
  integer k;
  always #5 clk = ~clk;
  rpd_peak_det uut (.i_clk_sys(clk), .i_rstn(rstn), .i_smp_vld(vld),
    .i_received_signal_strength(smp), .i_rx_run(run), .i_frame_sync_found(sync),
    .i_end_of_message(end_of_message), .i_data_bit_strobe(bs), .i_peak_start_bit_delay(dly),
    .i_rd_stb(stb), .i_rd_addr(addr), .o_rd_data(rdd), .o_rd_hit(hit),
    .o_payload_peak_level(pay), .o_running_peak_level(runv));
  rpd_host host (.i_clk_sys(clk), .o_rd_stb(stb), .o_rd_addr(addr));
  task final_report;
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cmp(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk) if (hit === 1'b1) cmp(rdd, q.size() ? q.pop_front() : ~rdd);
  task rx(input [7:0] ad, input [7:0] exp);
    q.push_back(exp);
    host.rd(ad);
  endtask
  task grp(input [7:0] base, input [7:0] span, output [7:0] av);
    integer i;
    reg [9:0] sum;
    reg [7:0] v;
    sum = 10'h000;
    for (i = 0; i < 4; i = i + 1) begin
      v = base + 8'($urandom % span);
      sum = sum + v;
      @(posedge clk) {vld, smp} <= {1'b1, v};
      @(posedge clk) vld <= 1'b0;
    end
    av = sum[9:2];
    repeat (3) @(posedge clk);
  endtask
  task pulse(input integer k);
    @(posedge clk) {sync, end_of_message, bs} <= 3'h4 >> k;
    @(posedge clk) {sync, end_of_message, bs} <= 3'h0;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    a = $urandom(32'h897D288E);
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rx(8'hAC, 8'h00);
    rx(8'hAD, 8'h00);
    run <= 1'b1;
    grp(8'hC8, 8'h37, e_run);
    grp(8'h00, 8'h32, a);
    rx(8'hAD, e_run);
    grp(8'h00, 8'h32, e_run);
    rx(8'hAD, e_run);
    run <= 1'b0;
    grp(8'hF0, 8'h0F, a);
    rx(8'hAD, e_run);
    rx(8'hAD, e_run);
    dly <= 8'h02;
    pulse(0);
    // High group lands inside the start delay
    grp(8'hF0, 8'h0F, a);
    pulse(2);
    pulse(2);
    grp(8'h64, 8'h32, e_pay);
    // Quieter tail stands for the strobe lag before end of message
    grp(8'h00, 8'h32, a);
    pulse(1);
    rx(8'hAC, e_pay);
    dly <= 8'h00;
    pulse(0);
    grp(8'h00, 8'h32, a);
    rx(8'hAC, e_pay);
    pulse(1);
    rx(8'hAC, a);
    // RF path off: trimmed noise sits at 02..05, read eleven times
    run <= 1'b1;
    for (k = 0; k < 11; k = k + 1) begin
      grp(8'h02, 8'h04, e_run);
      rx(8'hAD, e_run);
    end
    // RF path on with a strong input
    grp(8'hFC, 8'h03, e_run);
    rx(8'hAD, e_run);
    // Mid-run reset clears both registers
    repeat (2) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rx(8'hAC, 8'h00);
    rx(8'hAD, 8'h00);
    host.rd(8'h10);
    repeat (5) @(posedge clk);
    if (q.size() != 0) failures = failures + 1;
    final_report;
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures = failures + 1;
    final_report;
  end
endmodule // tb
